// >>> pmc_pkg.sv
// constants, types and register map of the power manager register bank
package pmc_pkg;

  localparam logic [7:0] PMC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PMC_OFS_STATUS  = 8'h04;
  localparam logic [7:0] PMC_OFS_WAKEUP  = 8'h0c;
  localparam logic [7:0] PMC_OFS_CLOCK   = 8'h14;

  localparam int PMC_ADDR_BITS = 8;
  localparam int PMC_GPIO_MAX  = 28;
  localparam int PMC_FREQ_W    = 5;
  localparam int PMC_ALARM_BIT = 31;
  localparam int PMC_FORCE_BIT = 0;

  localparam logic [31:0] PMC_WAKEUP_RST = 32'h0000_0003;
  localparam logic [4:0]  PMC_FREQ_RST   = 5'h00;

  localparam logic [1:0] PMC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PMC_HRESP_OKAY    = 2'h0;

  // sleep cause and hold flags, bit 0 lowest
  typedef struct packed {
    logic periph_hold;
    logic dram_hold;
    logic supply_fault;
    logic battery_fault;
    logic sw_sleep;
  } pmc_status_t;

  localparam pmc_status_t PMC_STATUS_RST = '0;

  // registered address phase
  typedef struct packed {
    logic                     valid;
    logic                     write;
    logic [PMC_ADDR_BITS-1:0] addr;
  } pmc_aphase_t;

  typedef enum logic [0:0] {
    PMC_AWAKE  = 1'b0,
    PMC_ASLEEP = 1'b1
  } pmc_mode_t;

endpackage

// >>> pmc_regs.sv
// power manager configuration and status registers on ahb-lite
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps

module pmc_regs
  import pmc_pkg::*;
#(
  parameter int GPIO_COUNT = 28
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [1:0]                 hresp,
  output logic [31:0]                hrdata,
  input  wire logic [GPIO_COUNT-1:0] gpio_edge,
  input  wire logic                  rtc_alarm,
  input  wire logic                  battery_fault_pin,
  input  wire logic                  supply_fault_pin,
  output logic [PMC_FREQ_W-1:0]      clock_freq_select,
  output logic                       sleep_mode,
  output logic                       dram_hold,
  output logic                       periph_hold
);

  // elaboration checks on parameters and package constants
  if (GPIO_COUNT < 2 || GPIO_COUNT > PMC_GPIO_MAX) begin : g_chk
    $error("pmc_regs: GPIO_COUNT must lie in 2..28");
  end

  if (PMC_FREQ_W != 5) begin : g_chk_freq
    $error("pmc_regs: frequency select must be five bits wide");
  end

  if ($bits(pmc_status_t) != 5) begin : g_chk_status
    $error("pmc_regs: status register must hold five flags");
  end

  if (PMC_ALARM_BIT < GPIO_COUNT) begin : g_chk_alarm
    $error("pmc_regs: alarm enable overlaps a gpio enable");
  end

  if (PMC_OFS_CONTROL[1:0] != 2'h0 ||
      PMC_OFS_STATUS[1:0]  != 2'h0 ||
      PMC_OFS_WAKEUP[1:0]  != 2'h0 ||
      PMC_OFS_CLOCK[1:0]   != 2'h0) begin : g_chk_align
    $error("pmc_regs: register offsets must be word aligned");
  end

  if (PMC_OFS_STATUS == PMC_OFS_WAKEUP ||
      PMC_OFS_WAKEUP == PMC_OFS_CLOCK) begin : g_chk_distinct
    $error("pmc_regs: register offsets must differ");
  end

  // read value of one register, reserved bits zero
  function automatic logic [31:0] reg_value(
    input logic [PMC_ADDR_BITS-1:0] a,
    input logic                     force_bit,
    input pmc_status_t              st,
    input logic [31:0]              wk,
    input logic [PMC_FREQ_W-1:0]    fq
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      PMC_OFS_CONTROL: v[PMC_FORCE_BIT] = force_bit;
      PMC_OFS_STATUS:  v[4:0] = st;
      PMC_OFS_WAKEUP:  v = wk;
      PMC_OFS_CLOCK:   v[PMC_FREQ_W-1:0] = fq;
      default:         v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // mask of writable wakeup enable bits
  function automatic logic [31:0] wake_mask();
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < GPIO_COUNT; i++) begin
      m[i] = 1'b1;
    end
    m[PMC_ALARM_BIT] = 1'b1;
    return m;
  endfunction

  localparam logic [31:0] WAKE_MASK = wake_mask();

  if ((PMC_WAKEUP_RST & ~WAKE_MASK) != 32'h0000_0000) begin : g_chk_wrst
    $error("pmc_regs: wakeup reset value sets reserved bits");
  end

  pmc_aphase_t             aphase;
  pmc_aphase_t             next_aphase;
  logic [31:0]             rdata;
  logic [31:0]             next_rdata;
  logic                    force_sleep_bit;
  logic                    next_force_sleep_bit;
  pmc_status_t             status;
  pmc_status_t             next_status;
  logic [31:0]             wakeup_source_enable;
  logic [31:0]             next_wakeup_source_enable;
  logic [PMC_FREQ_W-1:0]   core_clock_config;
  logic [PMC_FREQ_W-1:0]   next_core_clock_config;
  pmc_mode_t               mode;
  pmc_mode_t               next_mode;
  logic                    batt_prev;
  logic                    supply_prev;
  logic                    batt_rise;
  logic                    supply_rise;
  logic                    wake_hit;
  logic                    enter_sleep;
  logic                    wr_ctl;
  logic                    wr_sts;
  logic                    wr_wke;
  logic                    wr_clk;
  logic                    take;

  // per-source wake requests and fault pin history
  logic [GPIO_COUNT-1:0]   gpio_hit;
  logic                    alarm_hit;
  logic                    next_batt_prev;
  logic                    next_supply_prev;

  assign hreadyout = 1'b1;
  assign hresp     = PMC_HRESP_OKAY;
  assign hrdata    = rdata;

  assign clock_freq_select = core_clock_config;
  assign sleep_mode        = (mode == PMC_ASLEEP);
  assign dram_hold         = status.dram_hold;
  assign periph_hold       = status.periph_hold;

  // bus address phase and read data
  assign take = hsel && hready && htrans == PMC_HTRANS_NONSEQ;

  always_comb begin
    next_aphase = '0;
    next_rdata  = 32'h0000_0000;
    if (take) begin
      next_aphase.valid = 1'b1;
      next_aphase.write = hwrite;
      next_aphase.addr  = haddr[PMC_ADDR_BITS-1:0];
      if (!hwrite) begin
        next_rdata = reg_value(haddr[PMC_ADDR_BITS-1:0],
                               force_sleep_bit, status,
                               wakeup_source_enable,
                               core_clock_config);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase <= '0;
      rdata  <= 32'h0000_0000;
    end else begin
      aphase <= next_aphase;
      rdata  <= next_rdata;
    end
  end

  // data phase write strobes, decoded by offset
  always_comb begin
    wr_ctl = 1'b0;
    wr_sts = 1'b0;
    wr_wke = 1'b0;
    wr_clk = 1'b0;
    if (aphase.valid && aphase.write) begin
      unique case (aphase.addr)
        PMC_OFS_CONTROL: wr_ctl = 1'b1;
        PMC_OFS_STATUS:  wr_sts = 1'b1;
        PMC_OFS_WAKEUP:  wr_wke = 1'b1;
        PMC_OFS_CLOCK:   wr_clk = 1'b1;
        default:         wr_ctl = 1'b0;
      endcase
    end
  end

  // fault edges and wake sources
  assign batt_rise   = battery_fault_pin && !batt_prev;
  assign supply_rise = supply_fault_pin && !supply_prev;

  for (genvar g = 0; g < GPIO_COUNT; g++) begin : g_wake
    assign gpio_hit[g] = gpio_edge[g] && wakeup_source_enable[g];
  end

  assign alarm_hit = rtc_alarm && wakeup_source_enable[PMC_ALARM_BIT];
  assign wake_hit  = (|gpio_hit) || alarm_hit;

  // previous fault pin levels for rise detection
  always_comb begin
    next_batt_prev   = battery_fault_pin;
    next_supply_prev = supply_fault_pin;
  end

  assign enter_sleep = mode == PMC_AWAKE &&
                       (force_sleep_bit || batt_rise || supply_rise);

  // mode and control bit
  always_comb begin
    next_mode            = mode;
    next_force_sleep_bit = force_sleep_bit;
    if (wr_ctl && hwdata[PMC_FORCE_BIT]) begin
      next_force_sleep_bit = 1'b1;
    end
    unique case (mode)
      PMC_AWAKE: begin
        if (enter_sleep) begin
          next_mode = PMC_ASLEEP;
        end
      end
      PMC_ASLEEP: begin
        if (wake_hit) begin
          next_mode            = PMC_AWAKE;
          next_force_sleep_bit = 1'b0;
        end
      end
    endcase
  end

  // sticky status, hardware set wins over write-one clear
  always_comb begin
    next_status = status;
    if (wr_sts) begin
      next_status = status & ~pmc_status_t'(hwdata[4:0]);
    end
    if (mode == PMC_AWAKE && force_sleep_bit) begin
      next_status.sw_sleep = 1'b1;
    end
    if (battery_fault_pin) begin
      next_status.battery_fault = 1'b1;
    end
    if (mode == PMC_AWAKE && supply_rise) begin
      next_status.supply_fault = 1'b1;
    end
    if (mode == PMC_ASLEEP && wake_hit) begin
      next_status.dram_hold   = 1'b1;
      next_status.periph_hold = 1'b1;
    end
  end

  // configuration registers
  always_comb begin
    next_wakeup_source_enable = wakeup_source_enable;
    next_core_clock_config    = core_clock_config;
    if (wr_wke) begin
      next_wakeup_source_enable = hwdata & WAKE_MASK;
    end
    if (batt_rise || supply_rise) begin
      next_wakeup_source_enable = PMC_WAKEUP_RST;
    end
    if (wr_clk) begin
      next_core_clock_config = hwdata[PMC_FREQ_W-1:0];
    end
  end

  // mode and control bit registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode            <= PMC_AWAKE;
      force_sleep_bit <= 1'b0;
    end else begin
      mode            <= next_mode;
      force_sleep_bit <= next_force_sleep_bit;
    end
  end

  // status flags, cleared by the hardware reset or by a write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= PMC_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  // configuration register state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wakeup_source_enable <= PMC_WAKEUP_RST;
      core_clock_config    <= PMC_FREQ_RST;
    end else begin
      wakeup_source_enable <= next_wakeup_source_enable;
      core_clock_config    <= next_core_clock_config;
    end
  end

  // fault pin history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      batt_prev   <= 1'b0;
      supply_prev <= 1'b0;
    end else begin
      batt_prev   <= next_batt_prev;
      supply_prev <= next_supply_prev;
    end
  end

endmodule // pmc_regs

// >>> pmc_regs_assertions.sv
// port checker for the power manager register bank
`timescale 1ns/1ps
module pmc_regs_assertions
  import pmc_pkg::*;
#(parameter int GPIO_COUNT = 28) (
  input wire logic                  hclk,
  input wire logic                  hresetn,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [GPIO_COUNT-1:0] gpio_edge,
  input wire logic                  rtc_alarm,
  input wire logic                  supply_fault_pin,
  input wire logic [PMC_FREQ_W-1:0] clock_freq_select,
  input wire logic                  sleep_mode,
  input wire logic                  dram_hold,
  input wire logic                  periph_hold
);
  logic       wr_q;
  logic [7:0] ad_q;
  logic       st_wr;
  // write data phase tracker
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      ad_q <= 8'h00;
    end else begin
      wr_q <= hsel & hready & hwrite & (htrans == PMC_HTRANS_NONSEQ);
      ad_q <= haddr[7:0];
    end
  end
  assign st_wr = wr_q && ad_q == PMC_OFS_STATUS;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_freq_write: assert property (
    wr_q && ad_q == PMC_OFS_CLOCK |=> clock_freq_select == $past(hwdata[4:0]))
    else $error("clock select differs from write");
  a_freq_keep: assert property (
    !(wr_q && ad_q == PMC_OFS_CLOCK) |=> $stable(clock_freq_select))
    else $error("clock select changed without write");
  a_force_sleep: assert property (
    wr_q && ad_q == PMC_OFS_CONTROL && hwdata[0] && !sleep_mode |-> ##2 sleep_mode)
    else $error("force bit did not enter sleep");
  a_supply_sleep: assert property (
    !sleep_mode && $rose(supply_fault_pin) |=> sleep_mode)
    else $error("supply fault did not enter sleep");
  a_stay_asleep: assert property (
    sleep_mode && gpio_edge == '0 && !rtc_alarm |=> sleep_mode)
    else $error("woke without a source");
  a_wake_holds: assert property (
    $fell(sleep_mode) |-> dram_hold && periph_hold)
    else $error("holds not set on wake");
  a_dram_keep: assert property (
    dram_hold && !(st_wr && hwdata[3]) |=> dram_hold)
    else $error("dram hold dropped without clear");
  a_periph_clear: assert property (
    periph_hold && !sleep_mode && st_wr && hwdata[4] |=> !periph_hold)
    else $error("peripheral hold not cleared");
endmodule // pmc_regs_assertions

bind pmc_regs pmc_regs_assertions #(.GPIO_COUNT(GPIO_COUNT)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .gpio_edge(gpio_edge), .rtc_alarm(rtc_alarm),
  .supply_fault_pin(supply_fault_pin),
  .clock_freq_select(clock_freq_select), .sleep_mode(sleep_mode),
  .dram_hold(dram_hold), .periph_hold(periph_hold));

// >>> power_mgr_cfg_status_regs_tb.sv
// self-checking bench for the power manager register bank
`timescale 1ns/1ps
module power_mgr_cfg_status_regs_tb
  import pmc_pkg::*;
;
  logic        hclk = '0, hresetn = '0, hsel = '0, hwrite = '0;
  logic        rtc = '0, batt = '0, sup = '0;
  logic [1:0]  htrans = '0;
  logic [27:0] gpio = '0;
  logic [31:0] haddr = '0, hwdata = '0, rd, rnd = 32'h2b342471;
  logic [31:0] m_freq = '0, m_wake = 32'h3, m_stat = '0;
  logic [7:0]  ofs [4] = '{8'h14, 8'h0c, 8'h04, 8'h08};
  wire         rdy, slp, dh, ph;
  wire  [31:0] hrdata;
  wire  [4:0]  freq;
  int          err_count, checks_done, cyc;

  pmc_regs #(.GPIO_COUNT(28)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hreadyout(rdy), .hresp(), .hrdata(hrdata),
    .gpio_edge(gpio), .rtc_alarm(rtc), .battery_fault_pin(batt),
    .supply_fault_pin(sup), .clock_freq_select(freq),
    .sleep_mode(slp), .dram_hold(dh), .periph_hold(ph));

  initial forever #2 hclk = ~hclk;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'h1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= PMC_HTRANS_NONSEQ;
    do @(posedge hclk); while (rdy !== 1'h1);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'h1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
    case (a)
      PMC_OFS_CLOCK: m_freq = d & 32'h1f;
      PMC_OFS_WAKEUP: m_wake = d & 32'h8fff_ffff;
      PMC_OFS_STATUS: m_stat = m_stat & ~(d & 32'h1f);
      default: ;
    endcase
  endtask

  task automatic rc(input logic [7:0] a);
    xfer(1'h0, a, 32'h0);
    chk(rd, a == PMC_OFS_CLOCK ? m_freq : a == PMC_OFS_WAKEUP ? m_wake :
        a == PMC_OFS_STATUS ? m_stat : 32'h0);
  endtask

  task automatic all_regs;
    for (int i = 0; i < 4; i++) rc(ofs[i]);
  endtask

  task automatic pins(input logic [2:0] e);
    @(posedge hclk);
    chk({29'h0, slp, dh, ph}, {29'h0, e});
  endtask

  task automatic pulse(input int i);
    gpio <= 28'h1 << i;
    rtc <= (i == 28);
    @(posedge hclk);
    gpio <= '0;
    rtc <= 1'h0;
    @(posedge hclk);
  endtask

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    all_regs;
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      wr(PMC_OFS_CLOCK, rnd);
      wr(PMC_OFS_WAKEUP, ~rnd);
      wr(8'h08, rnd);
      all_regs;
      chk({27'h0, freq}, m_freq);
    end
    wr(PMC_OFS_WAKEUP, 32'h20);
    wr(PMC_OFS_CONTROL, 32'h1);
    m_stat[0] = 1'h1;
    @(posedge hclk);
    pins(3'h4);
    pulse(4);
    pins(3'h4);
    pulse(28);
    pins(3'h4);
    pulse(5);
    m_stat = m_stat | 32'h18;
    pins(3'h3);
    all_regs;
    wr(PMC_OFS_STATUS, 32'h0);
    wr(PMC_OFS_STATUS, 32'h8);
    pins(3'h1);
    wr(PMC_OFS_STATUS, 32'hffff_ffff);
    all_regs;
    wr(PMC_OFS_WAKEUP, 32'h8000_0000);
    sup <= 1'h1;
    m_wake = 32'h3;
    m_stat = 32'h4;
    @(posedge hclk);
    pins(3'h4);
    all_regs;
    wr(PMC_OFS_WAKEUP, 32'h8000_0000);
    pulse(28);
    m_stat = m_stat | 32'h18;
    pins(3'h3);
    sup <= 1'h0;
    wr(PMC_OFS_STATUS, 32'h1f);
    wr(PMC_OFS_CONTROL, 32'h1);
    m_stat = 32'h3;
    m_wake = 32'h3;
    @(posedge hclk);
    batt <= 1'h1;
    sup <= 1'h1;
    repeat (2) @(posedge hclk);
    batt <= 1'h0;
    all_regs;
    pulse(1);
    m_stat = m_stat | 32'h18;
    pins(3'h3);
    sup <= 1'h0;
    wr(PMC_OFS_CLOCK, 32'h15);
    hresetn <= 1'h0;
    m_freq = '0;
    m_stat = '0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    all_regs;
    pins(3'h0);
    tally_and_finish;
  end
endmodule // power_mgr_cfg_status_regs_tb
